// [hdl/mbm_bit_map.sv]
/*
 * Fieldbus bit map of a motor drive: coils onto the command word and
 * relay outputs, discrete inputs from the status word and delayed digital
 * inputs, and the error-code holding registers 90 to 95.
 * Assumes a query engine that splits each query into item accesses on
 * REQ and reports the end of every query on QRY; all inputs but SYS_RST synchronous.
 */
// Overview of operation
// - coils are single bits, readable and writable
// - references count from one, no offset
// - first profile maps coils one to sixteen
// - second profile maps its own coil set
// - coils 33 to 37 drive five relays
// - discrete inputs are single read-only bits
// - first profile maps inputs one to fifteen
// - second profile maps its own input set
// - inputs 33 to 38 show delayed inputs
// - log describes last query, success clears error
// - writing one to register 90 clears log
// - failed query's function code is stored
// - detail code loads on device failure
// - detail codes 00h, 02h, 03h, 05h, 65h
// - last failed item reference is stored
// - last item written without error is stored
// - last item read without error is stored
// - unrecoverable action failure answers exception 04h
`timescale 1ns/1ps
module mbm_bit_map
    import mbm_pkg::*;
(
    input wire logic MCLK, // system clock, 100 MHz
    input wire logic SYS_RST, // asynchronous reset, active high
    input wire logic PROFILE_SEL, // 0 first profile, 1 second
    input wire logic REQ_VALID, // item access strobe
    input wire mbm_req_t REQ, // item access
    input wire logic QRY_DONE, // end-of-query strobe
    input wire mbm_qry_t QRY, // end-of-query report
    input wire logic [31:0] STATUS_WORD, // drive status bits
    input wire logic [5:0] DI_DELAYED, // delayed digital inputs
    output logic RSP_VALID, // answer strobe
    output logic [7:0] RSP_EXC, // exception code, 00h when good
    output logic [7:0] RSP_DETAIL, // detail code with 04h
    output logic [15:0] RSP_RDATA, // read value
    output logic [31:0] CMD_WORD, // drive command bits
    output logic [4:0] RELAY_CTRL // relay outputs one to five
);

    logic profile_reg;
    logic [31:0] coil_word_reg;
    logic [31:0] coil_word_next;
    logic [4:0] relay_reg;
    logic [4:0] relay_next;
    logic [31:0] cmd_word_reg;
    logic rsp_valid_reg;
    logic [7:0] rsp_exc_reg;
    logic [7:0] rsp_exc_next;
    logic [7:0] rsp_detail_reg;
    logic [7:0] rsp_detail_next;
    logic [15:0] rsp_rdata_reg;
    logic [15:0] rsp_rdata_next;
    logic log_clear;
    mbm_log_t log_q;
    logic [31:0] cmask;
    logic [31:0] dmask;
    logic [4:0] bit_idx;
    logic [2:0] ext_idx;
    logic hit_word;
    logic hit_relay;
    logic hit_di;
    logic coil_bit;
    logic status_bit;
    logic di_bit;

    // the profile is sampled so one access never sees two maps
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            profile_reg <= 1'b0;
        end else begin
            profile_reg <= PROFILE_SEL;
        end
    end

    // reference decode shared by coils and discrete inputs
    always_comb begin
        cmask = coil_mask(profile_reg);
        dmask = disc_mask(profile_reg);
        // reference one is bit zero: no offset on the wire
        bit_idx = 5'(REQ.item - REF_ITEM_FIRST);
        ext_idx = 3'(REQ.item - REF_EXTRA_FIRST);
        hit_word = (REQ.item >= REF_ITEM_FIRST) &&
            (REQ.item <= REF_WORD_LAST);
        hit_relay = (REQ.item >= REF_EXTRA_FIRST) &&
            (REQ.item <= REF_RELAY_LAST);
        hit_di = (REQ.item >= REF_EXTRA_FIRST) &&
            (REQ.item <= REF_DI_LAST);
        coil_bit = coil_word_reg[bit_idx] & cmask[bit_idx];
        status_bit = STATUS_WORD[bit_idx] & dmask[bit_idx];
        di_bit = hit_di ? DI_DELAYED[ext_idx] : 1'b0;
    end

    // item access: one answer per strobe, next cycle
    always_comb begin
        rsp_rdata_next = 16'h0000;
        rsp_exc_next = EXC_NONE;
        rsp_detail_next = DET_NONE;
        coil_word_next = coil_word_reg;
        relay_next = relay_reg;
        log_clear = 1'b0;
        if (REQ_VALID) begin
            case (REQ.space)
                SP_COIL: begin
                    if (hit_word) begin
                        rsp_rdata_next = {15'h0000, coil_bit};
                        // reserved coils take the write and drop it
                        if (REQ.write && cmask[bit_idx]) begin
                            coil_word_next[bit_idx] = REQ.wdata[0];
                        end
                    end else if (hit_relay) begin
                        rsp_rdata_next = {15'h0000, relay_reg[ext_idx]};
                        if (REQ.write) begin
                            relay_next[ext_idx] = REQ.wdata[0];
                        end
                    end else begin
                        rsp_exc_next = EXC_ILLEGAL_ADDRESS;
                    end
                end
                SP_DISC: begin
                    if (REQ.write) begin
                        rsp_exc_next = EXC_ILLEGAL_FUNCTION;
                    end else if (hit_word) begin
                        rsp_rdata_next = {15'h0000, status_bit};
                    end else if (hit_di) begin
                        rsp_rdata_next = {15'h0000, di_bit};
                    end else begin
                        rsp_exc_next = EXC_ILLEGAL_ADDRESS;
                    end
                end
                SP_HOLD: begin
                    case (REQ.item)
                        REF_LOG_CLEAR: begin
                            // reads back zero: a command, not a state
                            if (REQ.write) begin
                                if (REQ.wdata == LOG_CLEAR_CMD) begin
                                    log_clear = 1'b1;
                                end else if (REQ.wdata != 16'h0000) begin
                                    rsp_exc_next = EXC_DEVICE_FAILURE;
                                    rsp_detail_next = DET_LIMIT;
                                end
                            end
                        end
                        REF_LOG_FUNC, REF_LOG_DETAIL, REF_LOG_FAILED,
                        REF_LOG_GOOD_WR, REF_LOG_GOOD_RD: begin
                            if (REQ.write) begin
                                rsp_exc_next = EXC_DEVICE_FAILURE;
                                rsp_detail_next = DET_GENERAL;
                            end else begin
                                rsp_rdata_next = log_word(REQ.item);
                            end
                        end
                        default: rsp_exc_next = EXC_ILLEGAL_ADDRESS;
                    endcase
                end
                default: rsp_exc_next = EXC_ILLEGAL_ADDRESS;
            endcase
        end
    end

    function automatic logic [15:0] log_word(input logic [15:0] item);
        case (item)
            REF_LOG_FUNC: log_word = log_q.func;
            REF_LOG_DETAIL: log_word = log_q.detail;
            REF_LOG_FAILED: log_word = log_q.failed;
            REF_LOG_GOOD_WR: log_word = log_q.good_wr;
            REF_LOG_GOOD_RD: log_word = log_q.good_rd;
            default: log_word = 16'h0000;
        endcase
    endfunction

    // coil storage; bits kept under one profile and reserved in the other return if it comes back
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            coil_word_reg <= COIL_WORD_RESET;
            relay_reg <= RELAY_RESET;
        end else begin
            coil_word_reg <= coil_word_next;
            relay_reg <= relay_next;
        end
    end

    // the drive only ever sees bits that mean something in the profile sampled one cycle before
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmd_word_reg <= COIL_WORD_RESET;
        end else begin
            cmd_word_reg <= coil_word_reg & cmask;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rsp_valid_reg <= 1'b0;
            rsp_exc_reg <= EXC_NONE;
            rsp_detail_reg <= DET_NONE;
            rsp_rdata_reg <= 16'h0000;
        end else begin
            rsp_valid_reg <= REQ_VALID;
            rsp_exc_reg <= rsp_exc_next;
            rsp_detail_reg <= rsp_detail_next;
            rsp_rdata_reg <= rsp_rdata_next;
        end
    end

    mbm_err_log u_log (
        .clk(MCLK),
        .rst(SYS_RST),
        .clear(log_clear),
        .ev_valid(QRY_DONE),
        .ev(QRY),
        .log_o(log_q)
    );

    assign RSP_VALID = rsp_valid_reg;
    assign RSP_EXC = rsp_exc_reg;
    assign RSP_DETAIL = rsp_detail_reg;
    assign RSP_RDATA = rsp_rdata_reg;
    assign CMD_WORD = cmd_word_reg;
    assign RELAY_CTRL = relay_reg;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    answer_timing_a: assert property (
        ##1 RSP_VALID == $past(REQ_VALID)
    ) else $error("answer not one cycle after request");

    coil_zero_a: assert property (
        REQ_VALID && REQ.space == SP_COIL && REQ.item == 16'h0000 |=>
            RSP_EXC == EXC_ILLEGAL_ADDRESS
    ) else $error("coil reference zero accepted");

    coil_readback_a: assert property (
        REQ_VALID && REQ.write && REQ.space == SP_COIL && hit_word &&
            cmask[bit_idx] ##1
        REQ_VALID && !REQ.write && REQ.space == SP_COIL &&
            REQ.item == $past(REQ.item) && $stable(profile_reg) |=>
            RSP_RDATA == {15'h0000, $past(REQ.wdata[0], 2)}
    ) else $error("coil does not read back");

    cmd_masked_a: assert property (
        (CMD_WORD & ~coil_mask($past(profile_reg))) == 32'h00000000
    ) else $error("reserved coil reaches the drive");

    relay_write_a: assert property (
        REQ_VALID && REQ.write && REQ.space == SP_COIL && hit_relay |=>
            RELAY_CTRL[$past(ext_idx)] == $past(REQ.wdata[0])
    ) else $error("relay does not follow its coil");

    disc_write_a: assert property (
        REQ_VALID && REQ.write && REQ.space == SP_DISC |=>
            RSP_EXC == EXC_ILLEGAL_FUNCTION
    ) else $error("discrete input write not refused");

    disc_reserved_a: assert property (
        REQ_VALID && !REQ.write && REQ.space == SP_DISC && hit_word &&
            !dmask[bit_idx] |=>
            RSP_EXC == EXC_NONE && RSP_RDATA == 16'h0000
    ) else $error("reserved discrete input not zero");

    disc_status_a: assert property (
        REQ_VALID && !REQ.write && REQ.space == SP_DISC && hit_word &&
            dmask[bit_idx] |=>
            RSP_RDATA == {15'h0000, $past(STATUS_WORD[bit_idx])}
    ) else $error("status bit misreported");

    di_read_a: assert property (
        REQ_VALID && !REQ.write && REQ.space == SP_DISC && hit_di |=>
            RSP_EXC == EXC_NONE &&
            RSP_RDATA == {15'h0000, $past(DI_DELAYED[ext_idx])}
    ) else $error("delayed input misreported");

    clear_value_a: assert property (
        REQ_VALID && REQ.write && REQ.space == SP_HOLD &&
            REQ.item == REF_LOG_CLEAR && REQ.wdata > LOG_CLEAR_CMD |=>
            RSP_EXC == EXC_DEVICE_FAILURE && RSP_DETAIL == DET_LIMIT &&
            (log_q == $past(log_q) || $past(QRY_DONE))
    ) else $error("bad clear value not refused");

    // idle cycles must not leave a stale answer on the outputs
    rsp_quiet_a: assert property (
        !REQ_VALID |=> RSP_EXC == EXC_NONE && RSP_DETAIL == DET_NONE &&
            RSP_RDATA == 16'h0000
    ) else $error("answer without request");

    relay_hold_a: assert property (
        !(REQ_VALID && REQ.write && REQ.space == SP_COIL && hit_relay) |=>
            $stable(RELAY_CTRL)
    ) else $error("relay moved without a write");

    cmd_follow_a: assert property (
        CMD_WORD == ($past(coil_word_reg) & $past(cmask))
    ) else $error("command word does not follow coils");

    reserved_coil_a: assert property (
        REQ_VALID && REQ.write && REQ.space == SP_COIL && hit_word &&
            !cmask[bit_idx] |=>
            RSP_EXC == EXC_NONE && coil_word_reg == $past(coil_word_reg)
    ) else $error("reserved coil write took effect");

    hold_read_only_a: assert property (
        REQ_VALID && REQ.write && REQ.space == SP_HOLD &&
            REQ.item >= REF_LOG_FUNC && REQ.item <= REF_LOG_GOOD_RD |=>
            RSP_EXC == EXC_DEVICE_FAILURE && RSP_DETAIL == DET_GENERAL
    ) else $error("log register write not refused");

    log_read_a: assert property (
        REQ_VALID && !REQ.write && REQ.space == SP_HOLD &&
            REQ.item == REF_LOG_FAILED |=>
            RSP_EXC == EXC_NONE && RSP_RDATA == $past(log_q.failed)
    ) else $error("failed item misreported");

    inreg_refused_a: assert property (
        REQ_VALID && REQ.space == SP_INREG |=>
            RSP_EXC == EXC_ILLEGAL_ADDRESS
    ) else $error("input register space answered");

    relay_cover_c: cover property (
        REQ_VALID && REQ.write && REQ.space == SP_COIL && hit_relay
    );

    disc_cover_c: cover property (
        REQ_VALID && REQ.space == SP_DISC && hit_di ##1 RSP_VALID
    );

    clear_cover_c: cover property (
        log_clear ##1 REQ_VALID && REQ.space == SP_HOLD
    );

    profile_cover_c: cover property (
        $rose(profile_reg) ##1 REQ_VALID && REQ.space == SP_COIL
    );

endmodule

// [hdl/mbm_err_log.sv]
/*
 * Error-code holding registers: failed function code, detail code,
 * failed item, last item written and read without error.
 * Assumes one end-of-query report per query from the query engine and a
 * clear pulse decoded by the bit map; both synchronous to clk.
 */
`timescale 1ns/1ps
module mbm_err_log
    import mbm_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // asynchronous reset
    input wire logic clear, // clear pulse
    input wire logic ev_valid, // query finished
    input wire mbm_qry_t ev, // query report
    output mbm_log_t log_o // register contents
);

    mbm_log_t log_reg;
    mbm_log_t log_next;

    // a report in the same cycle as a clear lands on top of the clear
    always_comb begin
        log_next = log_reg;
        if (clear) begin
            log_next = LOG_RESET;
        end
        if (ev_valid) begin
            if (ev.exc != EXC_NONE) begin
                log_next.func = {8'h00, ev.func};
                log_next.failed = ev.item;
                if (ev.exc == EXC_DEVICE_FAILURE) begin
                    log_next.detail = {8'h00, legal_detail(ev.detail)};
                end
            end else begin
                log_next.func = 16'h0000;
                log_next.detail = 16'h0000;
                if (ev.wr) begin
                    log_next.good_wr = ev.item;
                end
                if (ev.rd) begin
                    log_next.good_rd = ev.item;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            log_reg <= LOG_RESET;
        end else begin
            log_reg <= log_next;
        end
    end

    assign log_o = log_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    clear_empties_a: assert property (
        clear && !ev_valid |=> log_o == LOG_RESET
    ) else $error("log not empty after clear");

    fail_record_a: assert property (
        ev_valid && ev.exc != EXC_NONE |=>
            log_o.func == {8'h00, $past(ev.func)} &&
            log_o.failed == $past(ev.item)
    ) else $error("failed query not recorded");

    detail_load_a: assert property (
        ev_valid && ev.exc == EXC_DEVICE_FAILURE |=>
            log_o.detail == {8'h00, legal_detail($past(ev.detail))}
    ) else $error("detail code not loaded");

    good_clears_a: assert property (
        ev_valid && ev.exc == EXC_NONE |=>
            log_o.func == 16'h0000 && log_o.detail == 16'h0000
    ) else $error("error indication kept after good query");

    good_write_a: assert property (
        ev_valid && ev.exc == EXC_NONE && ev.wr |=>
            log_o.good_wr == $past(ev.item)
    ) else $error("last good write not recorded");

    good_read_a: assert property (
        ev_valid && ev.exc == EXC_NONE && ev.rd |=>
            log_o.good_rd == $past(ev.item)
    ) else $error("last good read not recorded");

    fail_cover_c: cover property (
        ev_valid && ev.exc == EXC_DEVICE_FAILURE ##1 clear
    );

endmodule

// [hdl/mbm_pkg.sv]
/*
 * Shared definitions for the fieldbus bit map and query error log:
 * item references, per-profile masks, exception and detail codes,
 * reset values, request/report carriers and small decode functions.
 * Assumes the query engine hands over items by their 1-based reference.
 */
package mbm_pkg;

    // data spaces of a request
    typedef enum logic [1:0] {
        SP_COIL  = 2'h0,
        SP_DISC  = 2'h1,
        SP_INREG = 2'h2,
        SP_HOLD  = 2'h3
    } mbm_space_t;

    // one item access from the query engine
    typedef struct packed {
        logic       write;
        mbm_space_t space;
        logic [15:0] item;
        logic [15:0] wdata;
    } mbm_req_t;

    // end-of-query report from the query engine
    typedef struct packed {
        logic [7:0]  func;
        logic [7:0]  exc;
        logic [7:0]  detail;
        logic [15:0] item;
        logic        wr;
        logic        rd;
    } mbm_qry_t;

    // contents of the error-code holding registers
    typedef struct packed {
        logic [15:0] func;
        logic [15:0] detail;
        logic [15:0] failed;
        logic [15:0] good_wr;
        logic [15:0] good_rd;
    } mbm_log_t;

    // item references, counted from one
    localparam logic [15:0] REF_ITEM_FIRST = 16'h0001;
    localparam logic [15:0] REF_WORD_LAST = 16'h0020;
    localparam logic [15:0] REF_EXTRA_FIRST = 16'h0021;
    localparam logic [15:0] REF_RELAY_LAST = 16'h0025;
    localparam logic [15:0] REF_DI_LAST = 16'h0026;
    localparam logic [15:0] REF_LOG_CLEAR = 16'h005a;
    localparam logic [15:0] REF_LOG_FUNC = 16'h005b;
    localparam logic [15:0] REF_LOG_DETAIL = 16'h005c;
    localparam logic [15:0] REF_LOG_FAILED = 16'h005d;
    localparam logic [15:0] REF_LOG_GOOD_WR = 16'h005e;
    localparam logic [15:0] REF_LOG_GOOD_RD = 16'h005f;
    localparam logic [15:0] LOG_CLEAR_CMD = 16'h0001;

    // items that carry a meaning in each profile
    localparam logic [31:0] COIL_MASK_P1 = 32'h0000ffff;
    localparam logic [31:0] COIL_MASK_P2 = 32'h03c33bf3;
    localparam logic [31:0] DISC_MASK_P1 = 32'h00007fff;
    localparam logic [31:0] DISC_MASK_P2 = 32'h07c1f39b;

    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_DEVICE_FAILURE = 8'h04;

    localparam logic [7:0] DET_NONE = 8'h00;
    localparam logic [7:0] DET_LIMIT = 8'h02;
    localparam logic [7:0] DET_INDEX = 8'h03;
    localparam logic [7:0] DET_TYPE = 8'h05;
    localparam logic [7:0] DET_GENERAL = 8'h65;

    localparam logic [31:0] COIL_WORD_RESET = 32'h00000000;
    localparam logic [4:0] RELAY_RESET = 5'h00;
    localparam mbm_log_t LOG_RESET = '0;

    function automatic logic [31:0] coil_mask(input logic prof);
        coil_mask = prof ? COIL_MASK_P2 : COIL_MASK_P1;
    endfunction

    function automatic logic [31:0] disc_mask(input logic prof);
        disc_mask = prof ? DISC_MASK_P2 : DISC_MASK_P1;
    endfunction

    // unknown detail codes fold into the general error
    function automatic logic [7:0] legal_detail(input logic [7:0] d);
        case (d)
            DET_NONE, DET_LIMIT, DET_INDEX, DET_TYPE, DET_GENERAL:
                legal_detail = d;
            default: legal_detail = DET_GENERAL;
        endcase
    endfunction

endpackage

// [verif/mbm_bit_map_tb_top.sv]
/*
 * Self-checking bench of the bit map and error log: accesses and
 * reports go through the client model, expected answers are queued.
 * Assumes nothing beyond the design and the client model.
 */
`timescale 1ns/1ps
module mbm_bit_map_tb_top;
    import mbm_pkg::*;
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic PROFILE_SEL = 1'b0;
    logic [31:0] STATUS_WORD = '0;
    logic [5:0] DI_DELAYED = '0;
    logic REQ_VALID, QRY_DONE, RSP_VALID;
    mbm_req_t REQ;
    mbm_qry_t QRY;
    logic [7:0] RSP_EXC, RSP_DETAIL;
    logic [15:0] RSP_RDATA;
    logic [31:0] CMD_WORD;
    logic [4:0] RELAY_CTRL;
    int mismatches = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'h2bfd48f6;
    logic [32:0] exp_q[$];
    logic [32:0] e;

    always #5 MCLK = ~MCLK;

    mbm_client i_cli (.MCLK(MCLK), .REQ_VALID(REQ_VALID), .REQ(REQ),
        .QRY_DONE(QRY_DONE), .QRY(QRY));

    mbm_bit_map i_dut (.MCLK(MCLK), .SYS_RST(SYS_RST),
        .PROFILE_SEL(PROFILE_SEL), .REQ_VALID(REQ_VALID), .REQ(REQ),
        .QRY_DONE(QRY_DONE), .QRY(QRY), .STATUS_WORD(STATUS_WORD),
        .DI_DELAYED(DI_DELAYED), .RSP_VALID(RSP_VALID), .RSP_EXC(RSP_EXC),
        .RSP_DETAIL(RSP_DETAIL), .RSP_RDATA(RSP_RDATA),
        .CMD_WORD(CMD_WORD), .RELAY_CTRL(RELAY_CTRL));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_tests++;
        if (seen !== expd) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, expd);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d errors %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // c set means the read value is compared as well
    task automatic ex(input logic w, input mbm_space_t s, input int it,
        input logic [15:0] d, input logic [7:0] x, input logic [7:0] dt,
        input logic [15:0] r, input logic c);
        exp_q.push_back({c, dt, x, r});
        i_cli.acc(w, s, 16'(it), d);
    endtask

    task automatic lg(input logic [15:0] a, b, c, d, f);
        logic [15:0] v[5];
        v = '{a, b, c, d, f};
        for (int k = 0; k < 5; k++) ex(0, SP_HOLD, 91 + k, 0, 0, 0, v[k], 1);
        i_cli.idle();
    endtask

    always @(negedge MCLK) begin
        if (RSP_VALID === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else begin
                e = exp_q.pop_front();
                check(RSP_EXC, e[23:16]);
                check(RSP_DETAIL, e[31:24]);
                if (e[32]) check(RSP_RDATA, e[15:0]);
            end
        end
    end

    initial begin
        #200us;
        mismatches++;
        complete_run();
    end

    initial begin
        logic [31:0] st, di, mk;
        logic [4:0] rl;
        repeat (5) @(posedge MCLK);
        @(negedge MCLK);
        SYS_RST = 1'b0;
        check(CMD_WORD, 0);
        check(RELAY_CTRL, 0);
        for (int i = 0; i < 5; i++) begin
            st = rnd();
            rl[i] = st[0];
            ex(1, SP_COIL, 33 + i, st[15:0], 0, 0, 0, 0);
        end
        for (int i = 0; i < 5; i++) ex(0, SP_COIL, 33 + i, 0, 0, 0, rl[i], 1);
        i_cli.idle();
        check(RELAY_CTRL, rl);
        for (int i = 1; i <= 32; i++) ex(1, SP_COIL, i, 1, 0, 0, 0, 0);
        i_cli.idle();
        @(negedge MCLK);
        check(CMD_WORD, COIL_MASK_P1);
        PROFILE_SEL = 1'b1;
        repeat (3) @(negedge MCLK);
        // coils reserved under the first profile were never stored
        check(CMD_WORD, COIL_MASK_P1 & COIL_MASK_P2);
        for (int i = 1; i <= 32; i++) begin
            ex(1, SP_COIL, i, 1, 0, 0, 0, 0);
            ex(0, SP_COIL, i, 0, 0, 0, 16'(COIL_MASK_P2[i-1]), 1);
        end
        i_cli.idle();
        check(CMD_WORD, COIL_MASK_P2);
        for (int p = 0; p < 2; p++) begin
            @(negedge MCLK);
            PROFILE_SEL = p[0];
            st = rnd();
            di = rnd();
            STATUS_WORD = st;
            DI_DELAYED = di[5:0];
            mk = p ? DISC_MASK_P2 : DISC_MASK_P1;
            repeat (2) @(negedge MCLK);
            for (int i = 1; i <= 38; i++)
                ex(0, SP_DISC, i, 0, 0, 0, (i <= 32) ? 16'(st[i-1] & mk[i-1])
                    : 16'(di[i-33]), 1);
            i_cli.idle();
        end
        ex(1, SP_DISC, 1, 1, 8'h01, 0, 0, 0);
        ex(0, SP_COIL, 0, 0, 8'h02, 0, 0, 0);
        ex(0, SP_COIL, 38, 0, 8'h02, 0, 0, 0);
        ex(0, SP_DISC, 39, 0, 8'h02, 0, 0, 0);
        ex(0, SP_INREG, 1, 0, 8'h02, 0, 0, 0);
        ex(1, SP_HOLD, 90, 2, 8'h04, 8'h02, 0, 0);
        ex(1, SP_HOLD, 91, 0, 8'h04, 8'h65, 0, 0);
        i_cli.rep(8'h03, 8'h04, 8'h02, 16'h0005, 0, 0);
        lg(16'h0003, 16'h0002, 16'h0005, 0, 0);
        i_cli.rep(8'h10, 8'h04, 8'h07, 16'h0009, 0, 0);
        lg(16'h0010, 16'h0065, 16'h0009, 0, 0);
        i_cli.rep(8'h06, 8'h00, 8'h00, 16'h002a, 1, 0);
        i_cli.rep(8'h03, 8'h00, 8'h00, 16'h0013, 0, 1);
        lg(0, 0, 16'h0009, 16'h002a, 16'h0013);
        ex(1, SP_HOLD, 90, 0, 0, 0, 0, 0);
        lg(0, 0, 16'h0009, 16'h002a, 16'h0013);
        ex(1, SP_HOLD, 90, 1, 0, 0, 0, 0);
        ex(0, SP_HOLD, 90, 0, 0, 0, 0, 1);
        lg(0, 0, 0, 0, 0);
        for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(negedge MCLK);
        if (exp_q.size() != 0) mismatches++;
        complete_run();
    end
endmodule

// [verif/mbm_client.sv]
/*
 * Client model at the far side: issues item accesses and end-of-query
 * reports, changing its outputs only at the falling edge of MCLK.
 * Assumes the bench calls its tasks in sequence and MCLK runs freely.
 */
`timescale 1ns/1ps
module mbm_client
    import mbm_pkg::*;
(
    input wire logic MCLK, // system clock
    output logic REQ_VALID, // item access strobe
    output mbm_req_t REQ, // item access
    output logic QRY_DONE, // end-of-query strobe
    output mbm_qry_t QRY // end-of-query report
);
    initial begin
        REQ_VALID = 1'b0;
        REQ = '0;
        QRY_DONE = 1'b0;
        QRY = '0;
    end

    // strobe stays up so that calls in a row go back to back
    task automatic acc(input logic w, input mbm_space_t s,
        input logic [15:0] it, input logic [15:0] d);
        @(negedge MCLK);
        QRY_DONE = 1'b0;
        REQ_VALID = 1'b1;
        REQ = '{w, s, it, d};
    endtask

    task automatic rep(input logic [7:0] f, input logic [7:0] x,
        input logic [7:0] dt, input logic [15:0] it, input logic wr,
        input logic rd);
        @(negedge MCLK);
        REQ_VALID = 1'b0;
        QRY_DONE = 1'b1;
        QRY = '{f, x, dt, it, wr, rd};
        @(negedge MCLK);
        QRY_DONE = 1'b0;
        QRY = ~QRY;
    endtask

    // released lines show the inverse, never the last value
    task automatic idle();
        @(negedge MCLK);
        REQ_VALID = 1'b0;
        QRY_DONE = 1'b0;
        REQ = ~REQ;
        QRY = ~QRY;
    endtask
endmodule
